// ==== logic/strap_config_map.svh ====
// Purpose: offsets, field positions, reset values and split encodings for the strap decoder
// Assumes: twenty strap pins, one core clock at 125 MHz
// Notes: definitions only
`ifndef STRAP_CONFIG_MAP_SVH
`define STRAP_CONFIG_MAP_SVH

// ----------------------------------------
// strap field layout
// ----------------------------------------
`define STRAP_WIDTH 20
`define STRAP_LANE_ORDER_BIT 2
`define STRAP_DEBUG_POLICY_BIT 3
`define STRAP_SPLIT_HI 6
`define STRAP_SPLIT_LO 5
// unterminated pins read as one
`define STRAP_RESET_VALUE 20'hFFFFF
// in reset every pin counts as open
`define STRAP_OPEN_RESET_VALUE 20'h00000
// spare pins: 1:0, 4, 19:7
`define STRAP_SPARE_MASK 20'hFFF93

// ----------------------------------------
// split encodings
// ----------------------------------------
`define SPLIT_X8_X4_X4 2'h0
`define SPLIT_RESERVED 2'h1
`define SPLIT_X8_X8 2'h2
`define SPLIT_X16 2'h3

`endif

// ==== logic/strap_config_pkg.sv ====
// Purpose: types shared by the strap decoder files
// Assumes: nothing
// Notes: numbers live in strap_config_map.svh
package strap_config_pkg;
    // port split of the x16 port
    typedef enum logic [1:0] {
        split_x8_x4_x4 = 2'h0,
        split_reserved = 2'h1,
        split_x8_x8 = 2'h2,
        split_x16 = 2'h3
    } port_split_t;

    // capture sequencer states, one-hot
    typedef enum logic [2:0] {
        st_reset = 3'h1,
        st_capture = 3'h2,
        st_hold = 3'h4
    } capture_state_t;
endpackage

// ==== logic/strap_sync_if.sv ====
// Purpose: carries synchronised pin levels from the synchroniser to the decoder
// Assumes: one clock domain
// Notes: none
`timescale 1ns/1ns
interface strap_sync_if;
    logic [19:0] strap_level; // synchronised strap pins
    logic pm_level; // synchronised sideband status
    modport source (output strap_level, output pm_level);
    modport sink (input strap_level, input pm_level);
endinterface

// ==== logic/strap_pin_sync.sv ====
// Purpose: two-flop synchroniser for strap pins and sideband status
// Assumes: pins are asynchronous to ref_clk
// Notes: first stage read only by second stage
`timescale 1ns/1ns
`include "strap_config_map.svh"
module strap_pin_sync
    import strap_config_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [19:0] strap_pin,
    input wire logic pm_sideband_status,
    strap_sync_if.source sync
);
    logic [19:0] strap_meta; // first stage
    logic [19:0] strap_stable; // second stage
    logic pm_meta; // first stage
    logic pm_stable; // second stage
    logic [19:0] next_strap_meta;
    logic [19:0] next_strap_stable;
    logic next_pm_meta;
    logic next_pm_stable;

    // ----------------------------------------
    // next values
    // ----------------------------------------
    always_comb
    begin
        next_strap_meta = strap_pin;
        next_strap_stable = strap_meta;
        next_pm_meta = pm_sideband_status;
        next_pm_stable = pm_meta;
        if (srst)
        begin
            // open pins idle at one
            next_strap_meta = `STRAP_RESET_VALUE;
            next_strap_stable = `STRAP_RESET_VALUE;
            next_pm_meta = 1'b0;
            next_pm_stable = 1'b0;
        end
    end

    // registers
    always_ff @(posedge ref_clk)
    begin
        strap_meta <= next_strap_meta;
        strap_stable <= next_strap_stable;
        pm_meta <= next_pm_meta;
        pm_stable <= next_pm_stable;
    end

    assign sync.strap_level = strap_stable;
    assign sync.pm_level = pm_stable;
endmodule

// ==== logic/strap_config_decoder.sv ====
// Purpose: decodes configuration straps and receives sideband power status
// Assumes: straps stable around reset release; open pins flagged per pin
// Notes: settings latch once after reset and hold until the next reset
// Function
// - open strap pins read as one
// - bit 2 selects normal or reversed lanes
// - bit 3 chooses debug register or override
// - spare strap bits carry no function
// - receive and interpret sideband power status
// - twenty strap bits, only bits 2, 3, 5 and 6 a setting
`timescale 1ns/1ns
`include "strap_config_map.svh"
module strap_config_decoder
    import strap_config_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [19:0] strap_pin,
    input wire logic [19:0] strap_pin_driven,
    input wire logic pm_sideband_status,
    input wire logic debug_access_control_reg,
    output logic [19:0] strap_value,
    output logic strap_valid,
    output logic lane_reversed,
    output logic debug_override,
    output logic debug_enable,
    output port_split_t port_split,
    output logic split_invalid,
    output logic [19:0] spare_straps,
    output logic pm_status,
    output logic pm_status_change
);
    strap_sync_if sync_bus();
    capture_state_t state; // capture sequencer
    capture_state_t next_state;
    logic [19:0] captured; // latched straps
    logic [19:0] next_captured;
    logic pm_level_q; // registered sideband status
    logic next_pm_level_q;
    logic pm_change_q; // change pulse
    logic next_pm_change_q;
    logic [19:0] resolved_pins; // undriven pins resolved to one
    logic [19:0] driven_meta; // first stage of the open-pin flags
    logic [19:0] driven_stable; // second stage of the open-pin flags
    logic [19:0] next_driven_meta;
    logic [19:0] next_driven_stable;
    logic next_lane_reversed; // decoded lane order
    logic next_debug_override; // decoded debug policy
    port_split_t next_port_split; // decoded split
    logic next_split_invalid; // reserved split seen
    logic [19:0] next_spare_straps; // spare bits

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // all twenty pins pass the synchroniser before any logic reads them
    strap_pin_sync u_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .strap_pin(strap_pin),
        .pm_sideband_status(pm_sideband_status),
        .sync(sync_bus.source)
    );

    // the open-pin flags come from the board too, so they get two flops as well
    // both paths have the same depth, so level and flag stay aligned
    always_comb
    begin
        next_driven_meta = strap_pin_driven;
        next_driven_stable = driven_meta;
        if (srst)
        begin
            // in reset every pin counts as open and so reads as one
            next_driven_meta = `STRAP_OPEN_RESET_VALUE;
            next_driven_stable = `STRAP_OPEN_RESET_VALUE;
        end
    end

    // open-pin flag registers
    always_ff @(posedge ref_clk)
    begin
        driven_meta <= next_driven_meta;
        driven_stable <= next_driven_stable;
    end

    // ----------------------------------------
    // pin resolution
    // ----------------------------------------
    // a pin the board leaves open reads as one, whatever level it shows
    // resolving after the flops keeps raw pin levels out of the logic
    assign resolved_pins = (sync_bus.strap_level & driven_stable) | ~driven_stable;

    // ----------------------------------------
    // field decode
    // ----------------------------------------
    // split code extracted from the two split bits
    function automatic port_split_t decode_split(input logic [19:0] straps);
        logic [1:0] code;
        code = straps[`STRAP_SPLIT_HI:`STRAP_SPLIT_LO];
        decode_split = port_split_t'(code);
    endfunction

    // ----------------------------------------
    // capture sequencer
    // ----------------------------------------
    // wait three cycles in st_reset after release so the synchroniser holds live pins
    // the settle count covers both synchroniser stages, so the capture never
    // takes the reset fill value of the flops in place of a live pin
    logic [1:0] settle; // settle counter
    logic [1:0] next_settle;
    always_comb
    begin
        next_state = state;
        next_captured = captured;
        next_settle = settle;
        unique case (state)
            st_reset:
            begin
                // synchroniser refilling
                if (settle == 2'h2)
                    next_state = st_capture;
                else
                    next_settle = settle + 2'h1;
            end
            st_capture:
            begin
                // single sample of the straps
                next_captured = resolved_pins;
                next_state = st_hold;
            end
            st_hold:
            begin
                // settings frozen until reset
                next_captured = captured;
            end
            default:
            begin
                next_state = st_reset;
            end
        endcase
        if (srst)
        begin
            next_state = st_reset;
            next_captured = `STRAP_RESET_VALUE;
            next_settle = 2'h0;
        end
    end

    // sequencer registers
    always_ff @(posedge ref_clk)
    begin
        state <= next_state;
        captured <= next_captured;
        settle <= next_settle;
    end

    // ----------------------------------------
    // sideband status
    // ----------------------------------------
    // registered level plus one-cycle change pulse
    // the pulse lines up with the level update, so a user can latch both at once
    // a change that lasts under one cycle may be missed by the synchroniser
    always_comb
    begin
        next_pm_level_q = sync_bus.pm_level;
        next_pm_change_q = (sync_bus.pm_level != pm_level_q);
        if (srst)
        begin
            next_pm_level_q = 1'b0;
            next_pm_change_q = 1'b0;
        end
    end

    // sideband registers
    always_ff @(posedge ref_clk)
    begin
        pm_level_q <= next_pm_level_q;
        pm_change_q <= next_pm_change_q;
    end

    // ----------------------------------------
    // decoded settings
    // ----------------------------------------
    // decoded from the next capture value, so each output flop moves with captured
    // registered outputs keep the decode gates off the paths into the port logic
    always_comb
    begin
        // one is normal numbering, zero reverses
        next_lane_reversed = ~next_captured[`STRAP_LANE_ORDER_BIT];
        // zero overrides the debug register default
        next_debug_override = ~next_captured[`STRAP_DEBUG_POLICY_BIT];
        next_port_split = decode_split(next_captured);
        next_split_invalid = (decode_split(next_captured) == split_reserved);
        // spare bits only reported, never acted on
        next_spare_straps = next_captured & `STRAP_SPARE_MASK;
    end

    // decoded setting registers
    always_ff @(posedge ref_clk)
    begin
        lane_reversed <= next_lane_reversed;
        debug_override <= next_debug_override;
        port_split <= next_port_split;
        split_invalid <= next_split_invalid;
        spare_straps <= next_spare_straps;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // latched straps, all ones while in reset
    assign strap_value = captured;
    // capture done, for users that poll
    assign strap_valid = (state == st_hold);
    // the strap picks between the register bit and a forced disable
    assign debug_enable = captured[`STRAP_DEBUG_POLICY_BIT] & debug_access_control_reg;
    // sideband level and its change pulse
    assign pm_status = pm_level_q;
    assign pm_status_change = pm_change_q;
endmodule

// ==== tb/strap_config_assertions.sv ====
// Purpose: port checker for the strap decoder
// Assumes: one clock, sync reset
// Notes: bound to the top module
`timescale 1ns/1ns
module strap_config_checker
    import strap_config_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [19:0] strap_pin,
    input wire logic [19:0] strap_pin_driven,
    input wire logic pm_sideband_status,
    input wire logic debug_access_control_reg,
    input wire logic [19:0] strap_value,
    input wire logic strap_valid,
    input wire logic lane_reversed,
    input wire logic debug_override,
    input wire logic debug_enable,
    input wire port_split_t port_split,
    input wire logic split_invalid,
    input wire logic [19:0] spare_straps,
    input wire logic pm_status,
    input wire logic pm_status_change
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    property p_lane; lane_reversed == !strap_value[2]; endproperty
    a_lane: assert property (p_lane) else $error("lane order wrong");
    property p_dbg; debug_override == !strap_value[3]
        && debug_enable == (strap_value[3] & debug_access_control_reg); endproperty
    a_dbg: assert property (p_dbg) else $error("debug policy wrong");
    property p_split; port_split == strap_value[6:5]
        && split_invalid == (port_split == split_reserved); endproperty
    a_split: assert property (p_split) else $error("split wrong");
    property p_spare; spare_straps == (strap_value & 20'hFFF93); endproperty
    a_spare: assert property (p_spare) else $error("spare bits wrong");
    property p_hold; strap_valid |=> strap_valid && $stable(strap_value); endproperty
    a_hold: assert property (p_hold) else $error("straps moved");
    property p_boot; $fell(srst) |-> strap_value == 20'hFFFFF && !strap_valid
        ##[3:8] strap_valid; endproperty
    a_boot: assert property (p_boot) else $error("capture timing wrong");
    property p_pulse; pm_status_change == (pm_status != $past(pm_status)); endproperty
    a_pulse: assert property (p_pulse) else $error("change pulse wrong");
    property p_pm; $rose(pm_sideband_status) |-> ##[1:4] pm_status; endproperty
    a_pm: assert property (p_pm) else $error("status slow");
endmodule
bind strap_config_decoder strap_config_checker chk_i (.*);

// ==== tb/strap_board_model.sv ====
// Purpose: board straps and platform sideband driver
// Assumes: open strap pins float; they show low here
// Notes: behavioural
`timescale 1ns/1ns
module strap_board_model
(
    input wire logic [19:0] board_val,
    input wire logic [19:0] board_mask,
    input wire logic pm_drive,
    output logic [19:0] strap_pin,
    output logic [19:0] strap_pin_driven,
    output logic pm_sideband_status
);
    // an open pin shows low here, so only the decoder can make it read one
    assign strap_pin = board_val & board_mask;
    assign strap_pin_driven = board_mask;
    // controller drives the one sideband line
    assign pm_sideband_status = pm_drive;
endmodule

// ==== tb/strap_config_decoder_bench.sv ====
// Purpose: self-checking bench for the strap decoder
// Assumes: inputs move 1 ns after the rising edge
// Notes: each boot holds reset 8 cycles
`timescale 1ns/1ns
module strap_config_decoder_bench;
    import strap_config_pkg::*;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [19:0] board_val = 20'h00000;
    logic [19:0] board_mask = 20'h00000;
    logic pm_drive = 1'b0;
    logic dbg_reg = 1'b0;
    logic [19:0] strap_pin, strap_pin_driven, strap_value, spare_straps;
    logic pm_sideband_status, strap_valid, lane_reversed, debug_override, debug_enable;
    logic split_invalid, pm_status, pm_status_change;
    port_split_t port_split;
    int bad_count = 0;
    int check_count = 0;
    always #4 ref_clk = ~ref_clk;
    strap_board_model board (.board_val(board_val), .board_mask(board_mask),
        .pm_drive(pm_drive), .strap_pin(strap_pin), .strap_pin_driven(strap_pin_driven),
        .pm_sideband_status(pm_sideband_status));
    strap_config_decoder dut (.ref_clk(ref_clk), .srst(srst), .strap_pin(strap_pin),
        .strap_pin_driven(strap_pin_driven), .pm_sideband_status(pm_sideband_status),
        .debug_access_control_reg(dbg_reg), .strap_value(strap_value),
        .strap_valid(strap_valid), .lane_reversed(lane_reversed),
        .debug_override(debug_override), .debug_enable(debug_enable),
        .port_split(port_split), .split_invalid(split_invalid),
        .spare_straps(spare_straps), .pm_status(pm_status),
        .pm_status_change(pm_status_change));
    task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // reset, capture, then judge every registered decoded output
    task automatic boot(input logic [19:0] v, input logic [19:0] m);
        logic [19:0] e;
        e = v | ~m;
        board_val = v;
        board_mask = m;
        srst = 1'b1;
        repeat (8) @(posedge ref_clk);
        #1 chk("reset straps", 20'hFFFFF, strap_value);
        chk("reset valid", 20'h0, 20'(strap_valid));
        srst = 1'b0;
        @(posedge ref_clk);
        #1 chk("early valid", 20'h0, 20'(strap_valid));
        repeat (3) @(posedge ref_clk);
        #1 chk("valid", 20'h1, 20'(strap_valid));
        chk("straps", e, strap_value);
        chk("lanes", 20'(!e[2]), 20'(lane_reversed));
        chk("override", 20'(!e[3]), 20'(debug_override));
        chk("split", 20'(e[6:5]), 20'(port_split));
        chk("invalid", 20'(e[6:5] == 2'h1), 20'(split_invalid));
        chk("spare", e & 20'hFFF93, spare_straps);
    endtask
    task automatic t_codes();
        for (int i = 0; i < 4; i++)
            boot({13'h0, i[1:0], 1'b0, i[0], i[1], 2'h0}, 20'hFFFFF);
        boot(20'h00000, 20'h00000);
        boot(20'h5A5A5, 20'hF0F0F);
        $display("done codes");
    endtask
    task automatic t_hold();
        boot(20'h00000, 20'hFFFFF);
        board_val = 20'hFFFFF;
        repeat (12) @(posedge ref_clk);
        #1 chk("held", 20'h00000, strap_value);
        chk("held valid", 20'h1, 20'(strap_valid));
        $display("done hold");
    endtask
    task automatic t_debug(input logic s);
        boot({16'h0, s, 3'h0}, 20'hFFFFF);
        for (int i = 0; i < 2; i++)
        begin
            dbg_reg = i[0];
            @(posedge ref_clk);
            #1 chk("debug", 20'(s & i[0]), 20'(debug_enable));
        end
        $display("done debug");
    endtask
    task automatic t_pm(input logic lvl);
        int p;
        p = 0;
        pm_drive = lvl;
        for (int k = 0; k < 8; k++)
        begin
            @(posedge ref_clk);
            #1 p += (pm_status_change === 1'b1);
        end
        chk("pm", 20'(lvl), 20'(pm_status));
        chk("pulses", 20'h1, 20'(p));
        $display("done pm");
    endtask
    task automatic complete_run();
        $display("checks %0d bad %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        #16000;
        bad_count++;
        complete_run();
    end
    initial
    begin
        t_codes();
        t_hold();
        t_debug(1'b1);
        t_debug(1'b0);
        t_pm(1'b1);
        t_pm(1'b0);
        complete_run();
    end
endmodule
